//--- common/fbm_defs.svh
`ifndef FBM_DEFS_SVH
`define FBM_DEFS_SVH
`define FBM_CLK_MHZ 32'h0000_0064
`define FBM_REFRESH_US 32'h0000_03E8
`define FBM_NUM_BLK 4'hC
`define FBM_LAST_BLK 4'hB
`define FBM_IMG_FIRST 8'h20
`define FBM_IMG_LAST 8'hDF
`define FBM_IMG_BLK_BIAS 4'h2
`define FBM_SRC_DEPTH 10'h200
`define FBM_REG_CTRL 12'h000
`define FBM_REG_STATUS 12'h004
`define FBM_REG_LEVEL_F0 12'h008
`define FBM_REG_LEVEL_F1 12'h00C
`define FBM_REG_LEVEL_I 12'h010
`define FBM_REG_INSTAT0 12'h014
`define FBM_REG_INSTAT1 12'h018
`define FBM_REG_INSTAT2 12'h01C
`define FBM_REG_CFG_PAGE 6'h01
`define FBM_CTRL_RUN 0
`define FBM_CTRL_KICK 1
`define FBM_CTRL_RST 1'h1
`define FBM_CFG_RST 11'h000
`define FBM_ITEM_ERR_F 6'h00
`define FBM_ITEM_STAT_F 6'h01
`define FBM_ITEM_ERRSTAT_I 6'h02
`define FBM_ITEM_VAL_F 6'h03
`define FBM_ITEM_VAL_I 6'h13
`define FBM_ITEM_VAL_D 6'h23
`define FBM_FETCH_F 3'h4
`define FBM_FETCH_I 3'h5
`define FBM_FETCH_NONE 3'h0
`endif

//--- common/fbm_pkg.sv
package fbm_pkg;
   // Builder sequencer states, one-hot.
   typedef enum logic [3:0] {
      FBM_ST_IDLE = 4'h1,
      FBM_ST_LOAD = 4'h2,
      FBM_ST_FETCH = 4'h4,
      FBM_ST_COMMIT = 4'h8
   } fbm_state_t;
   // Kind of content a data block carries.
   typedef enum logic [3:0] {
      FBM_K_NONE = 4'h0,
      FBM_K_OUT12 = 4'h1,
      FBM_K_OUT34 = 4'h2,
      FBM_K_OUT56 = 4'h3,
      FBM_K_OUT78 = 4'h4,
      FBM_K_FORCE_AB = 4'h5,
      FBM_K_FORCE_CD = 4'h6,
      FBM_K_SIG_AB = 4'h7,
      FBM_K_SIG_CD = 4'h8,
      FBM_K_LEVEL = 4'h9,
      FBM_K_INSTAT = 4'hA
   } fbm_kind_t;
   // Per-block configuration word: bits 10:8 source, 4 integer format, 3:0 kind.
   typedef struct packed {
      logic [2:0] fb;
      logic [2:0] rsv;
      logic is_int;
      logic [3:0] kind;
   } fbm_cfg_t;
   // One sixteen-byte data block, byte 0 in bits 127:120.
   typedef logic [127:0] fbm_line_t;
endpackage : fbm_pkg

//--- src/fbm_block_mapper.sv
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fbm_defs.svh"
module fbm_block_mapper #(
   parameter int unsigned REFRESH_CYCLES = `FBM_REFRESH_US * `FBM_CLK_MHZ // Cycles between passes.
) (
   input wire logic ref_clk, // System clock, 100 MHz.
   input wire logic sys_rst, // Synchronous reset, active high.
   input wire logic [11:0] avs_address, // Avalon byte address.
   input wire logic avs_read, // Avalon read request.
   input wire logic avs_write, // Avalon write request.
   input wire logic [31:0] avs_writedata, // Avalon write data.
   input wire logic [3:0] avs_byteenable, // Avalon byte enables.
   output var logic [31:0] avs_readdata, // Avalon read data.
   output var logic avs_waitrequest, // Avalon wait request.
   input wire logic img_rd, // Master-side read strobe.
   input wire logic [7:0] img_addr, // Image byte address of the block.
   output var fbm_pkg::fbm_line_t img_data, // Sixteen-byte block, byte 0 on top.
   output var logic img_valid // Pulse: img_data holds the answer.
);
   import fbm_pkg::*;

   // Number of the first value of a pair: outputs 0-7, forces 8-11, signals 12-15.
   function automatic logic [3:0] first_val(input fbm_kind_t kind);
      first_val = 4'h0;
      case (kind)
         FBM_K_OUT12: first_val = 4'h0;
         FBM_K_OUT34: first_val = 4'h2;
         FBM_K_OUT56: first_val = 4'h4;
         FBM_K_OUT78: first_val = 4'h6;
         FBM_K_FORCE_AB: first_val = 4'h8;
         FBM_K_FORCE_CD: first_val = 4'hA;
         FBM_K_SIG_AB: first_val = 4'hC;
         FBM_K_SIG_CD: first_val = 4'hE;
         default: first_val = 4'h0;
      endcase
   endfunction : first_val

   // How many source words a block needs; level, status and empty need none.
   function automatic logic [2:0] fetch_count(input fbm_cfg_t cfg);
      fetch_count = `FBM_FETCH_NONE;
      if (cfg.kind >= FBM_K_OUT12 && cfg.kind <= FBM_K_SIG_CD)
      begin
         fetch_count = cfg.is_int ? `FBM_FETCH_I : `FBM_FETCH_F;
      end
   endfunction : fetch_count

   // Source word index within a function block slot for each fetch step.
   function automatic logic [5:0] item_of(input logic is_int, input logic [2:0] step,
                                          input logic [3:0] v0);
      logic [5:0] v;
      v = {2'h0, v0};
      item_of = `FBM_ITEM_ERR_F;
      if (!is_int)
      begin
         case (step)
            3'h0: item_of = `FBM_ITEM_ERR_F;
            3'h1: item_of = `FBM_ITEM_STAT_F;
            3'h2: item_of = `FBM_ITEM_VAL_F + v;
            default: item_of = `FBM_ITEM_VAL_F + v + 6'h01;
         endcase
      end
      else
      begin
         case (step)
            3'h0: item_of = `FBM_ITEM_ERRSTAT_I;
            3'h1: item_of = `FBM_ITEM_VAL_I + v;
            3'h2: item_of = `FBM_ITEM_VAL_D + v;
            3'h3: item_of = `FBM_ITEM_VAL_I + v + 6'h01;
            default: item_of = `FBM_ITEM_VAL_D + v + 6'h01;
         endcase
      end
   endfunction : item_of

   // Lays out one block; w holds the fetched words, word k in bits 32k+31:32k.
   // misc holds level float 0/1, level integer, input status 0/1/2, top down.
   function automatic fbm_line_t build_line(input fbm_cfg_t cfg, input logic [159:0] w,
                                            input logic [191:0] misc);
      build_line = '0;
      case (cfg.kind)
         FBM_K_OUT12, FBM_K_OUT34, FBM_K_OUT56, FBM_K_OUT78,
         FBM_K_FORCE_AB, FBM_K_FORCE_CD, FBM_K_SIG_AB, FBM_K_SIG_CD:
         begin
            if (!cfg.is_int)
            begin
               // Error, status, first value, second value, each MSB first.
               build_line = {w[31:0], w[63:32], w[95:64], w[127:96]};
            end
            else
            begin
               // Error/status halfwords, then int word and dec halfword twice.
               build_line = {w[31:0], w[63:32], w[79:64],
                             w[127:96], w[143:128]};
            end
         end
         FBM_K_LEVEL:
         begin
            if (!cfg.is_int)
            begin
               build_line = {misc[191:160], misc[159:128], 64'h0};
            end
            else
            begin
               build_line = {misc[127:96], 96'h0};
            end
         end
         FBM_K_INSTAT:
         begin
            // Only a floating-point layout exists; integer format leaves it empty.
            if (!cfg.is_int)
            begin
               build_line = {misc[95:64], misc[63:32], misc[31:0], 32'h0};
            end
         end
         default: build_line = '0;
      endcase
   endfunction : build_line

   // Writes only the enabled byte lanes into an old register value.
   function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] be);
      merge_be = old;
      for (int b = 0; b < 4; b++)
      begin
         if (be[b])
         begin
            merge_be[8*b +: 8] = nw[8*b +: 8];
         end
      end
   endfunction : merge_be

   logic [1:0] acc_ff; // Bus access phase: 0 idle, 1 fetch, 2 answer.
   logic run_ff; // Periodic refresh enabled.
   logic [31:0] level_f0_ff; // Level states 1-16, floating-point word.
   logic [31:0] level_f1_ff; // Level states 17-32, floating-point word.
   logic [31:0] level_i_ff; // Level states 1-16 high half, 17-32 low half.
   logic [95:0] instat_ff; // Input status words 0, 1, 2 from top down.
   fbm_cfg_t cfg_ff [0:`FBM_NUM_BLK-1]; // Per-block configuration.
   logic [31:0] tick_cnt_ff; // Refresh divider.
   logic tick_ff; // One-cycle refresh pulse.
   logic pend_ff; // A pass is requested.
   fbm_state_t state_ff; // Builder state.
   logic [3:0] blk_ff; // Block being built.
   fbm_cfg_t cur_ff; // Snapshot of the block's configuration.
   logic [2:0] nfetch_ff; // Words to fetch for this block.
   logic [2:0] step_ff; // Fetches issued so far.
   logic rd_pend_ff; // A builder read is in flight.
   logic [2:0] cap_ff; // Word slot of the read in flight.
   logic [159:0] words_ff; // Fetched source words.
   logic [7:0] pass_ff; // Completed passes, wraps.
   logic [31:0] src_rdata; // Source memory read data.
   logic [31:0] reg_rdata; // Register read mux.
   logic is_src; // Access targets source memory.
   logic is_cfg; // Access targets a configuration register.
   logic [3:0] cfg_idx; // Configuration register index.
   logic bus_grant; // Bus takes the memory read port this cycle.
   logic issue; // Builder issues a memory read this cycle.
   logic wr_now; // Register write takes effect at this edge.
   logic kick; // Software asks for an immediate pass.
   logic [8:0] src_raddr; // Memory read index.

   assign is_src = avs_address[11];
   assign is_cfg = (avs_address[11:6] == `FBM_REG_CFG_PAGE) && (avs_address[5:2] < `FBM_NUM_BLK);
   assign cfg_idx = avs_address[5:2];
   // The bus read beats the builder for one cycle; the builder merely waits.
   assign bus_grant = (acc_ff == 2'h0) && avs_read && is_src;
   assign issue = (state_ff == FBM_ST_FETCH) && (step_ff < nfetch_ff) && !bus_grant;
   assign wr_now = (acc_ff == 2'h2) && avs_write;
   assign kick = wr_now && (avs_address == `FBM_REG_CTRL) && avs_byteenable[0]
                 && avs_writedata[`FBM_CTRL_KICK];
   // Each block pulls from the function block its configuration names.
   assign src_raddr = bus_grant ? avs_address[10:2]
                      : {cur_ff.fb, item_of(cur_ff.is_int, step_ff,
                                            first_val(fbm_kind_t'(cur_ff.kind)))};

   // Source values, written by software, read by bus and builder.
   fbm_src_ram u_src (
      .clk(ref_clk),
      .we(wr_now && is_src),
      .be(avs_byteenable),
      .waddr(avs_address[10:2]),
      .wdata(avs_writedata),
      .raddr(src_raddr),
      .rdata(src_rdata)
   );

   // The twelve finished blocks that the master reads.
   fbm_line_store u_img (
      .clk(ref_clk),
      .rst(sys_rst),
      .we(state_ff == FBM_ST_COMMIT),
      .waddr(blk_ff),
      .wdata(build_line(cur_ff, words_ff,
                        {level_f0_ff, level_f1_ff, level_i_ff, instat_ff})),
      .re(img_rd),
      .rzero((img_addr < `FBM_IMG_FIRST) || (img_addr > `FBM_IMG_LAST)),
      .raddr(img_addr[7:4] - `FBM_IMG_BLK_BIAS),
      .rdata(img_data)
   );

   // Read mux for the register page; unmapped words read as zero.
   always_comb
   begin
      reg_rdata = 32'h0000_0000;
      if (is_cfg)
      begin
         reg_rdata = {21'h0, cfg_ff[cfg_idx]};
      end
      else
      begin
         case (avs_address)
            `FBM_REG_CTRL: reg_rdata = {31'h0, run_ff};
            `FBM_REG_STATUS: reg_rdata = {12'h0, blk_ff, pass_ff, 6'h0, pend_ff,
                                          state_ff != FBM_ST_IDLE};
            `FBM_REG_LEVEL_F0: reg_rdata = level_f0_ff;
            `FBM_REG_LEVEL_F1: reg_rdata = level_f1_ff;
            `FBM_REG_LEVEL_I: reg_rdata = level_i_ff;
            `FBM_REG_INSTAT0: reg_rdata = instat_ff[95:64];
            `FBM_REG_INSTAT1: reg_rdata = instat_ff[63:32];
            `FBM_REG_INSTAT2: reg_rdata = instat_ff[31:0];
            default: reg_rdata = 32'h0000_0000;
         endcase
      end
   end

   // Bus handshake: every access waits two edges, so a memory read has time.
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         acc_ff <= 2'h0;
         avs_waitrequest <= 1'h1;
         avs_readdata <= 32'h0000_0000;
      end
      else if (acc_ff == 2'h0)
      begin
         if (avs_read || avs_write)
         begin
            acc_ff <= 2'h1;
         end
      end
      else if (acc_ff == 2'h1)
      begin
         // Answer now; the master takes it at the next edge.
         acc_ff <= 2'h2;
         avs_waitrequest <= 1'h0;
         avs_readdata <= avs_read ? (is_src ? src_rdata : reg_rdata) : 32'h0000_0000;
      end
      else
      begin
         acc_ff <= 2'h0;
         avs_waitrequest <= 1'h1;
      end
   end

   // Control and source registers, written when the master sees waitrequest low.
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         run_ff <= `FBM_CTRL_RST;
         level_f0_ff <= 32'h0000_0000;
         level_f1_ff <= 32'h0000_0000;
         level_i_ff <= 32'h0000_0000;
         instat_ff <= 96'h0;
      end
      else if (wr_now)
      begin
         case (avs_address)
            `FBM_REG_CTRL:
            begin
               if (avs_byteenable[0])
               begin
                  run_ff <= avs_writedata[`FBM_CTRL_RUN];
               end
            end
            `FBM_REG_LEVEL_F0: level_f0_ff <= merge_be(level_f0_ff, avs_writedata,
                                                       avs_byteenable);
            `FBM_REG_LEVEL_F1: level_f1_ff <= merge_be(level_f1_ff, avs_writedata,
                                                       avs_byteenable);
            `FBM_REG_LEVEL_I: level_i_ff <= merge_be(level_i_ff, avs_writedata,
                                                     avs_byteenable);
            `FBM_REG_INSTAT0: instat_ff[95:64] <= merge_be(instat_ff[95:64], avs_writedata,
                                                           avs_byteenable);
            `FBM_REG_INSTAT1: instat_ff[63:32] <= merge_be(instat_ff[63:32], avs_writedata,
                                                           avs_byteenable);
            `FBM_REG_INSTAT2: instat_ff[31:0] <= merge_be(instat_ff[31:0], avs_writedata,
                                                          avs_byteenable);
            default: run_ff <= run_ff;
         endcase
      end
   end

   // Block configuration; the reserved field is kept at zero.
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < `FBM_NUM_BLK; i++)
         begin
            cfg_ff[i] <= `FBM_CFG_RST;
         end
      end
      else if (wr_now && is_cfg)
      begin
         // The masked word is cut to the eleven configuration bits on purpose.
         cfg_ff[cfg_idx] <= fbm_cfg_t'(11'(merge_be({21'h0, cfg_ff[cfg_idx]}, avs_writedata,
                                                    avs_byteenable) & 32'h0000_071F));
      end
   end

   // Refresh divider: one pulse per period while refresh runs.
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || !run_ff)
      begin
         tick_cnt_ff <= 32'h0000_0000;
         tick_ff <= 1'h0;
      end
      else if (tick_cnt_ff >= REFRESH_CYCLES - 32'h0000_0001)
      begin
         tick_cnt_ff <= 32'h0000_0000;
         tick_ff <= 1'h1;
      end
      else
      begin
         tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
         tick_ff <= 1'h0;
      end
   end

   // Pass request; a new request in the cycle a pass starts is kept.
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         pend_ff <= 1'h0;
      end
      else if (tick_ff || kick)
      begin
         pend_ff <= 1'h1;
      end
      else if (state_ff == FBM_ST_IDLE)
      begin
         pend_ff <= 1'h0;
      end
   end

   // Builder: walks the twelve blocks, fetches words, commits each line whole.
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         state_ff <= FBM_ST_IDLE;
         blk_ff <= 4'h0;
         cur_ff <= `FBM_CFG_RST;
         nfetch_ff <= `FBM_FETCH_NONE;
         step_ff <= 3'h0;
         pass_ff <= 8'h00;
      end
      else
      begin
         unique case (state_ff)
            FBM_ST_IDLE:
            begin
               if (pend_ff)
               begin
                  blk_ff <= 4'h0;
                  state_ff <= FBM_ST_LOAD;
               end
            end
            FBM_ST_LOAD:
            begin
               // Snapshot so a configuration write cannot tear this block.
               cur_ff <= cfg_ff[blk_ff];
               nfetch_ff <= fetch_count(cfg_ff[blk_ff]);
               step_ff <= 3'h0;
               state_ff <= FBM_ST_FETCH;
            end
            FBM_ST_FETCH:
            begin
               if (issue)
               begin
                  step_ff <= step_ff + 3'h1;
               end
               else if (step_ff == nfetch_ff && !rd_pend_ff)
               begin
                  state_ff <= FBM_ST_COMMIT;
               end
            end
            FBM_ST_COMMIT:
            begin
               if (blk_ff == `FBM_LAST_BLK)
               begin
                  pass_ff <= pass_ff + 8'h01;
                  state_ff <= FBM_ST_IDLE;
               end
               else
               begin
                  blk_ff <= blk_ff + 4'h1;
                  state_ff <= FBM_ST_LOAD;
               end
            end
         endcase
      end
   end

   // Captures fetched words; slots not fetched stay zero.
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         rd_pend_ff <= 1'h0;
         cap_ff <= 3'h0;
         words_ff <= 160'h0;
      end
      else
      begin
         rd_pend_ff <= issue;
         if (issue)
         begin
            cap_ff <= step_ff;
         end
         if (state_ff == FBM_ST_LOAD)
         begin
            words_ff <= 160'h0;
         end
         else if (rd_pend_ff)
         begin
            for (int k = 0; k < 5; k++)
            begin
               if (cap_ff == k[2:0])
               begin
                  words_ff[32*k +: 32] <= src_rdata;
               end
            end
         end
      end
   end

   // Read answer strobe for the master side.
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         img_valid <= 1'h0;
      end
      else
      begin
         img_valid <= img_rd;
      end
   end
endmodule : fbm_block_mapper
`default_nettype wire

//--- src/fbm_line_store.sv
`timescale 1ns/1ps
`default_nettype none
`include "fbm_defs.svh"
module fbm_line_store (
   input wire logic clk, // System clock.
   input wire logic rst, // Synchronous reset, active high.
   input wire logic we, // Commit a whole block line.
   input wire logic [3:0] waddr, // Block index 0 to 11.
   input wire fbm_pkg::fbm_line_t wdata, // Complete new line.
   input wire logic re, // Read request from the master side.
   input wire logic rzero, // Address lies outside the block area.
   input wire logic [3:0] raddr, // Block index to read.
   output var fbm_pkg::fbm_line_t rdata // Registered line read data.
);
   import fbm_pkg::*;

   // Image of the twelve blocks, cleared so unused blocks read as zero.
   fbm_line_t lines_ff [0:`FBM_NUM_BLK-1];

   // A line is replaced in one edge, so a reader sees it whole.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < `FBM_NUM_BLK; i++)
         begin
            lines_ff[i] <= '0;
         end
      end
      else if (we)
      begin
         lines_ff[waddr] <= wdata;
      end
   end

   // Read port; addresses outside the area answer with zero.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rdata <= '0;
      end
      else if (re)
      begin
         rdata <= rzero ? '0 : lines_ff[raddr];
      end
   end
endmodule : fbm_line_store
`default_nettype wire

//--- src/fbm_src_ram.sv
`timescale 1ns/1ps
`default_nettype none
`include "fbm_defs.svh"
module fbm_src_ram (
   input wire logic clk, // System clock.
   input wire logic we, // Write strobe.
   input wire logic [3:0] be, // Byte enables of the write.
   input wire logic [8:0] waddr, // Write word index.
   input wire logic [31:0] wdata, // Write data.
   input wire logic [8:0] raddr, // Read word index.
   output var logic [31:0] rdata // Registered read data, one cycle after raddr.
);
   // Source values of all function blocks; no reset, software loads it.
   logic [31:0] mem [0:`FBM_SRC_DEPTH-1];

   // Byte-lane writes so software can update one halfword alone.
   always_ff @(posedge clk)
   begin
      for (int b = 0; b < 4; b++)
      begin
         if (we && be[b])
         begin
            mem[waddr][8*b +: 8] <= wdata[8*b +: 8];
         end
      end
   end

   // Registered read port.
   always_ff @(posedge clk)
   begin
      rdata <= mem[raddr];
   end
endmodule : fbm_src_ram
`default_nettype wire

//--- test/fbm_block_mapper_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module fbm_block_mapper_asserts (
   input wire logic ref_clk, // Clock.
   input wire logic sys_rst, // Reset.
   input wire logic avs_read, // Read.
   input wire logic avs_write, // Write.
   input wire logic avs_waitrequest, // Wait.
   input wire logic img_rd, // Strobe.
   input wire logic [7:0] img_addr, // Address.
   input wire fbm_pkg::fbm_line_t img_data, // Block.
   input wire logic img_valid // Pulse.
);
   import fbm_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // The wait line drops for exactly one cycle, two edges after the request.
   sequence s_ans;
      avs_waitrequest ##1 !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   rd_answer_a: assert property ($rose(avs_read) |=> s_ans) else $error("read answer");
   wr_answer_a: assert property ($rose(avs_write) |=> s_ans) else $error("write answer");
   idle_wait_a: assert property (!avs_read && !avs_write |-> avs_waitrequest)
      else $error("wait low while idle");
   img_pulse_a: assert property (img_rd |=> img_valid)
      else $error("no block answer");
   img_quiet_a: assert property (!img_rd |=> !img_valid && $stable(img_data))
      else $error("block changed unasked");
   low_zero_a: assert property (img_rd && img_addr < 8'h20 |=> img_data == '0)
      else $error("base area not zero");
   high_zero_a: assert property (img_rd && img_addr > 8'hDF |=> img_data == '0)
      else $error("past area not zero");
   rst_clear_a: assert property ($fell(sys_rst) |-> avs_waitrequest && img_data == '0)
      else $error("reset state wrong");
endmodule : fbm_block_mapper_asserts
bind fbm_block_mapper fbm_block_mapper_asserts fbm_block_mapper_asserts_inst (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .img_rd(img_rd), .img_addr(img_addr),
   .img_data(img_data), .img_valid(img_valid));
`default_nettype wire

//--- test/fbm_img_master.sv
`timescale 1ns/1ps
`default_nettype none
// Fieldbus master model: reads one whole sixteen-byte block per strobe.
module fbm_img_master (
   input wire logic ref_clk, // Clock.
   output var logic img_rd, // Strobe.
   output var logic [7:0] img_addr, // Address.
   input wire fbm_pkg::fbm_line_t img_data, // Block.
   input wire logic img_valid // Pulse.
);
   import fbm_pkg::*;
   initial img_rd = 1'h0;
   initial img_addr = 8'h00;
   // The address is inverted once the strobe is gone, so a stale block cannot match.
   task automatic fetch(input logic [7:0] a, input int gap, output fbm_line_t d);
      repeat (gap) @(posedge ref_clk);
      img_rd <= 1'h1;
      img_addr <= a;
      @(posedge ref_clk);
      img_rd <= 1'h0;
      img_addr <= ~a;
      // The answer launched at the taking edge is read at the next rising edge.
      @(posedge ref_clk);
      d = (img_valid === 1'h1) ? img_data : 'x;
   endtask : fetch
endmodule : fbm_img_master
`default_nettype wire

//--- test/tb_fbm_block_mapper.sv
`timescale 1ns/1ps
`default_nettype none
module tb_fbm_block_mapper;
   import fbm_pkg::*;
   logic ref_clk = 1'h0, sys_rst = 1'h1, avs_read = 1'h0, avs_write = 1'h0;
   logic avs_waitrequest, img_rd, img_valid;
   logic [11:0] avs_address = 12'h000;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q, m [8][51], lv [6];
   logic [7:0] img_addr, c;
   fbm_line_t img_data, ln;
   int kd [12], fb [12], r, seed = 32'h5f83, error_cnt = 0, n_tests = 0, cyc = 0;
   always #5 ref_clk = ~ref_clk;
   // A short refresh period keeps the periodic passes running during the test.
   fbm_block_mapper #(.REFRESH_CYCLES(400)) fbm_block_mapper_inst (.ref_clk(ref_clk),
      .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .img_rd(img_rd),
      .img_addr(img_addr), .img_data(img_data), .img_valid(img_valid));
   fbm_img_master fbm_img_master_inst (.ref_clk(ref_clk), .img_rd(img_rd),
      .img_addr(img_addr), .img_data(img_data), .img_valid(img_valid));
   // Bus master: holds the request until the edge that sees the wait line low.
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      avs_write <= wr;
      avs_read <= ~wr;
      avs_address <= a;
      avs_writedata <= d;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'h0);
      q = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
   endtask : bus
   task automatic chk(input fbm_line_t g, input fbm_line_t e);
      n_tests++;
      if (g !== e)
      begin
         error_cnt++;
         $display("CHECK FAILED %0t: got %h exp %h", $time, g, e);
      end
   endtask : chk
   // Expected block; r selects float (0) or integer (1) format in each round.
   function automatic fbm_line_t exp_line(int b);
      int v, f;
      if (b > 11 || kd[b] == 0 || kd[b] > 10 || kd[b] == 10 && r == 1)
         return '0;
      v = 2 * kd[b] - 2;
      f = fb[b];
      if (kd[b] == 9)
         return r ? {lv[2], 96'h0} : {lv[0], lv[1], 64'h0};
      if (kd[b] == 10)
         return {lv[3], lv[4], lv[5], 32'h0};
      if (r)
         return {m[f][2], m[f][19 + v], m[f][35 + v][15:0], m[f][20 + v], m[f][36 + v][15:0]};
      return {m[f][0], m[f][1], m[f][3 + v], m[f][4 + v]};
   endfunction : exp_line
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         error_cnt++;
         wrap_up();
      end
   end
   initial
   begin
      repeat (6) @(posedge ref_clk);
      sys_rst <= 1'h0;
      bus(1'h0, 12'h040, 32'h0);
      chk(128'(q), 128'h0);
      bus(1'h0, 12'h100, 32'h0);
      chk(128'(q), 128'h0);
      for (r = 0; r < 2; r++)
      begin
         for (int i = 0; i < 414; i++)
         begin
            q = $random(seed);
            if (i < 408) m[i / 51][i % 51] = q;
            else lv[i - 408] = q;
            bus(1'h1, i < 408 ? 12'(2048 + 4 * (i / 51 * 64 + i % 51)) : 12'(4 * i - 1624), q);
         end
         bus(1'h0, 12'h800, 32'h0);
         chk(128'(q), 128'(m[0][0]));
         bus(1'h0, 12'h010, 32'h0);
         chk(128'(q), 128'(lv[2]));
         for (int b = 0; b < 12; b++)
         begin
            kd[b] = (b + r) % 12;
            fb[b] = $random(seed) & 7;
            bus(1'h1, 12'(64 + 4 * b), {21'h0, 3'(fb[b]), 3'h0, 1'(r), 4'(kd[b])});
         end
         bus(1'h0, 12'h004, 32'h0);
         c = q[15:8];
         bus(1'h1, 12'h000, 32'h3);
         // Two finished passes guarantee one that began after every write.
         do bus(1'h0, 12'h004, 32'h0); while (8'(q[15:8] - c) < 8'h2);
         for (int b = 0; b < 14; b++)
         begin
            if (b < 12) c = 8'(32 + 16 * b + ($random(seed) & 15));
            else c = 8'((b - 12) * 224 + ($random(seed) & 31));
            fbm_img_master_inst.fetch(c, 1 + ($random(seed) & 3), ln);
            chk(ln, exp_line(b));
         end
         $display("round %0d done", r);
      end
      wrap_up();
   end
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : wrap_up
endmodule : tb_fbm_block_mapper
`default_nettype wire
